// file: verilog/wake_event_control.sv
// Wake-up event control and status with pattern store, APB slave.
// Assumes link_status is asynchronous, receive stream and wol_packet_rx
// are on clk, and soft_reset is a one-cycle controller reset on clk.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ns
`include "wake_params.svh"

module wake_event_control #(
    parameter int NUM_PATTERNS = 5
) (
    // Clock and resets
    input wire logic clk,
    input wire logic reset_n,
    input wire logic soft_reset,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Power configuration levels
    input wire logic pm_enable_cfg,
    input wire logic lan_wake_config,
    // Link and receive side
    input wire logic link_status,
    input wire wake_pkg::rx_byte_t rx_byte,
    input wire logic wol_packet_rx,
    // Events out
    output logic pm_event_status_set,
    output logic irq
);
    // ----------------------------------------
    // Elaboration check
    // ----------------------------------------
    if (NUM_PATTERNS < 1 || NUM_PATTERNS > 5) begin : g_bad_count
        $error("NUM_PATTERNS must be 1 to 5");
    end

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic crc_preset_select;
    logic [4:0] pattern_match_en;
    logic link_down_detect_en;
    logic link_up_detect_en;
    logic wake_frame_event_en;
    logic wol_packet_event_en;
    logic link_change_event_en;
    logic wake_frame_seen;
    logic wol_packet_seen;
    logic link_change_seen;
    logic [2:0] irq_mask;
    logic [31:0] pat_mem [0:`PAT_WORDS-1];
    logic [4:0] wr_ptr;
    logic link_meta;
    logic link_sync;
    logic link_prev;
    logic link_up_edge;
    logic link_down_edge;
    logic [NUM_PATTERNS-1:0] match_hit;
    logic ev_frame;
    logic ev_link;
    logic access;
    logic wr_wcs;
    logic wr_mask;
    logic wr_wpd;
    logic [2:0] w1c;
    logic [2:0] next_flags;
    logic [31:0] wcs_view;
    logic mapped;

    // ----------------------------------------
    // APB decode
    // ----------------------------------------

    // A write lands only on the edge that completes the access phase
    assign access = psel && penable && pready;
    assign wr_wcs = access && pwrite && (paddr == `WCS_ADDR);
    assign wr_mask = access && pwrite && (paddr == `IMASK_ADDR);
    assign wr_wpd = access && pwrite && (paddr == `WPD_ADDR);
    assign mapped = (paddr == `WCS_ADDR) || (paddr == `IMASK_ADDR) || (paddr == `WPD_ADDR);

    // Read view of the control/status word, reserved bits zero
    always_comb begin
        wcs_view = 32'h0000_0000;
        wcs_view[`CRC_SEL_BIT] = crc_preset_select;
        wcs_view[`PAT_EN_HI:`PAT_EN_LO] = pattern_match_en;
        wcs_view[`LINK_DOWN_BIT] = link_down_detect_en;
        wcs_view[`LINK_UP_BIT] = link_up_detect_en;
        wcs_view[`FRAME_EV_BIT] = wake_frame_event_en;
        wcs_view[`WOLPKT_EV_BIT] = wol_packet_event_en;
        wcs_view[`LINK_EV_BIT] = link_change_event_en;
        wcs_view[`FRAME_SEEN_BIT] = wake_frame_seen;
        wcs_view[`WOLPKT_SEEN_BIT] = wol_packet_seen;
        wcs_view[`LINK_SEEN_BIT] = link_change_seen;
    end

    // Answer one cycle after setup: no wait states, error on unmapped
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            if (psel && !penable) begin
                case (paddr)
                    `WCS_ADDR: prdata <= wcs_view;
                    `IMASK_ADDR: prdata <= {29'h0, irq_mask};
                    `WPD_ADDR: prdata <= pat_mem[wr_ptr];
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Control fields
    // ----------------------------------------

    // Cleared by either reset; the packet enable default follows the power config
    always_ff @(posedge clk) begin
        if (!reset_n || soft_reset) begin
            crc_preset_select <= 1'b0;
            pattern_match_en <= 5'h00;
            link_down_detect_en <= 1'b0;
            link_up_detect_en <= 1'b0;
            wake_frame_event_en <= 1'b0;
            wol_packet_event_en <= pm_enable_cfg && lan_wake_config;
            link_change_event_en <= 1'b0;
        end else if (wr_wcs) begin
            crc_preset_select <= pwdata[`CRC_SEL_BIT];
            pattern_match_en <= pwdata[`PAT_EN_HI:`PAT_EN_LO];
            link_down_detect_en <= pwdata[`LINK_DOWN_BIT];
            link_up_detect_en <= pwdata[`LINK_UP_BIT];
            wake_frame_event_en <= pwdata[`FRAME_EV_BIT];
            wol_packet_event_en <= pwdata[`WOLPKT_EV_BIT];
            link_change_event_en <= pwdata[`LINK_EV_BIT];
        end
    end

    // Interrupt mask, same layout as the three status flags
    always_ff @(posedge clk) begin
        if (!reset_n || soft_reset) begin
            irq_mask <= 3'h0;
        end else if (wr_mask) begin
            irq_mask <= pwdata[2:0];
        end
    end

    // ----------------------------------------
    // Pattern store
    // ----------------------------------------

    // Sequential loading: each write fills the next word, wrapping after 25
    always_ff @(posedge clk) begin
        if (!reset_n || soft_reset) begin
            wr_ptr <= 5'h00;
        end else if (wr_wpd) begin
            wr_ptr <= (wr_ptr == `PAT_LAST_IDX) ? 5'h00 : wr_ptr + 5'h01;
        end
    end

    // Words are flip-flops; contents are kept through soft reset
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            for (int i = 0; i < `PAT_WORDS; i++) begin
                pat_mem[i] <= 32'h0000_0000;
            end
        end else if (wr_wpd) begin
            pat_mem[wr_ptr] <= pwdata;
        end
    end

    // ----------------------------------------
    // Pattern matchers
    // ----------------------------------------

    // Pattern n sits at word 5n; its enable bit counts down from bit 29
    for (genvar g = 0; g < NUM_PATTERNS; g++) begin : g_pat
        wake_pkg::pattern_t pat;
        assign pat.mask = {pat_mem[g*`WORDS_PER_PAT+3], pat_mem[g*`WORDS_PER_PAT+2],
                           pat_mem[g*`WORDS_PER_PAT+1], pat_mem[g*`WORDS_PER_PAT]};
        assign pat.crc = pat_mem[g*`WORDS_PER_PAT+4][`CRC_HI:`CRC_LO];
        assign pat.offset = pat_mem[g*`WORDS_PER_PAT+4][`OFS_HI:0];
        wake_crc_matcher wake_crc_matcher_i (
            .clk(clk),
            .reset_n(reset_n),
            .pattern(pat),
            .enable(pattern_match_en[4-g]),
            .crc_preset_select(crc_preset_select),
            .rx_byte(rx_byte),
            .hit(match_hit[g])
        );
    end

    // ----------------------------------------
    // Link status watch
    // ----------------------------------------

    // Two flops before use; link_prev starts down, so an up link at reset
    // gives one up edge two cycles after reset, reported only if link-up detect is already on
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            link_meta <= 1'b0;
            link_sync <= 1'b0;
            link_prev <= 1'b0;
        end else begin
            link_meta <= link_status;
            link_sync <= link_meta;
            link_prev <= link_sync;
        end
    end

    assign link_up_edge = link_sync && !link_prev;
    assign link_down_edge = !link_sync && link_prev;

    // ----------------------------------------
    // Events and sticky flags
    // ----------------------------------------

    // Only individually enabled patterns can raise a frame event
    assign ev_frame = |match_hit;
    assign ev_link = (link_down_edge && link_down_detect_en)
                     || (link_up_edge && link_up_detect_en);

    // Write-one clear, but a same-cycle event wins over the clear
    always_comb begin
        w1c = wr_wcs ? pwdata[2:0] : 3'h0;
        next_flags[`FRAME_SEEN_BIT] = (wake_frame_seen && !w1c[`FRAME_SEEN_BIT])
                                      || ev_frame;
        next_flags[`WOLPKT_SEEN_BIT] = (wol_packet_seen && !w1c[`WOLPKT_SEEN_BIT])
                                       || wol_packet_rx;
        next_flags[`LINK_SEEN_BIT] = (link_change_seen && !w1c[`LINK_SEEN_BIT])
                                     || ev_link;
    end

    // Only power-up reset clears the flags; soft reset leaves them alone
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wake_frame_seen <= 1'b0;
            wol_packet_seen <= 1'b0;
            link_change_seen <= 1'b0;
        end else begin
            wake_frame_seen <= next_flags[`FRAME_SEEN_BIT];
            wol_packet_seen <= next_flags[`WOLPKT_SEEN_BIT];
            link_change_seen <= next_flags[`LINK_SEEN_BIT];
        end
    end

    // Pulse that sets the power-management event status bit elsewhere
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pm_event_status_set <= 1'b0;
        end else begin
            pm_event_status_set <= (ev_frame && wake_frame_event_en)
                                   || (wol_packet_rx && wol_packet_event_en)
                                   || (ev_link && link_change_event_en);
        end
    end

    // Level interrupt tracks the flags in the same cycle they change
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_flags & irq_mask);
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    property p_en_reset;
        soft_reset |=> pattern_match_en == 5'h00 && !wake_frame_event_en;
    endproperty
    a_en_reset: assert property (p_en_reset) else $error("enables not cleared");

    property p_link_down;
        link_down_edge && link_down_detect_en |=> link_change_seen;
    endproperty
    a_link_down: assert property (p_link_down) else $error("link down missed");

    property p_link_up;
        link_up_edge && link_up_detect_en |=> link_change_seen;
    endproperty
    a_link_up: assert property (p_link_up) else $error("link up missed");

    property p_frame_pme;
        ev_frame && wake_frame_event_en |=> pm_event_status_set && wake_frame_seen;
    endproperty
    a_frame_pme: assert property (p_frame_pme) else $error("frame event lost");

    property p_wol_default;
        soft_reset |=> wol_packet_event_en == $past(pm_enable_cfg && lan_wake_config);
    endproperty
    a_wol_default: assert property (p_wol_default) else $error("wol default wrong");

    property p_pme_cause;
        pm_event_status_set |-> $past(ev_frame && wake_frame_event_en)
            || $past(wol_packet_rx && wol_packet_event_en)
            || $past(ev_link && link_change_event_en);
    endproperty
    a_pme_cause: assert property (p_pme_cause) else $error("pm event uncaused");

    property p_wol_flag;
        wol_packet_rx |=> wol_packet_seen;
    endproperty
    a_wol_flag: assert property (p_wol_flag) else $error("wol flag missed");

    property p_lsc_cause;
        $rose(link_change_seen) |-> $past(ev_link);
    endproperty
    a_lsc_cause: assert property (p_lsc_cause) else $error("link flag uncaused");

    property p_flag_hold;
        soft_reset && !wr_wcs |=>
            ($past({wake_frame_seen, wol_packet_seen, link_change_seen})
             & ~{wake_frame_seen, wol_packet_seen, link_change_seen}) == 3'h0;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag lost on reset");

    property p_store;
        wr_wpd |=> pat_mem[$past(wr_ptr)] == $past(pwdata);
    endproperty
    a_store: assert property (p_store) else $error("pattern word not stored");

    property p_frame_flag;
        $rose(wake_frame_seen) |-> $past(|match_hit);
    endproperty
    a_frame_flag: assert property (p_frame_flag) else $error("frame flag uncaused");
endmodule

// file: verilog/wake_params.svh
// Constants of the wake-up event control block: offsets, fields, resets.
// Assumes inclusion by bare name; holds definitions only.
//
// Function
// - The CRC-16 accumulator starts at 0000h when the preset select is 0 and FFFFh when 1.
// - Five read/write pattern match enables sit at bits 29 to 25 and reset to 0.
// - With link-down detect on (bit 17), a link up-to-down change sets the link change flag.
// - With link-up detect on (bit 16), a link down-to-up change sets the link change flag.
// - With bit 10 set, a matched wake-up frame asserts the power-management event status.
// - With bit 9 set, a wake-on-LAN packet asserts that status; bit 9 resets to both power configs.
// - With bit 8 set, a link change event asserts the power-management event status.
// - Status bit 2 shows that a wake-up frame was received.
// - Status bit 1 shows that a wake-on-LAN broadcast packet was received.
// - Status bit 0 shows that a link status change event was detected.
// - Each pattern is five long words: four mask words, then CRC in 31:16, offset in 7:0.
`ifndef WAKE_PARAMS_SVH
`define WAKE_PARAMS_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define WCS_ADDR 8'h68
`define IMASK_ADDR 8'h6C
`define WPD_ADDR 8'h70

// ----------------------------------------
// Control/status field positions
// ----------------------------------------
`define CRC_SEL_BIT 30
`define PAT_EN_HI 29
`define PAT_EN_LO 25
`define LINK_DOWN_BIT 17
`define LINK_UP_BIT 16
`define FRAME_EV_BIT 10
`define WOLPKT_EV_BIT 9
`define LINK_EV_BIT 8
`define FRAME_SEEN_BIT 2
`define WOLPKT_SEEN_BIT 1
`define LINK_SEEN_BIT 0

// ----------------------------------------
// Pattern store layout and CRC
// ----------------------------------------
`define WORDS_PER_PAT 5
`define PAT_WORDS 25
`define PAT_LAST_IDX 5'h18
`define CRC_HI 31
`define CRC_LO 16
`define OFS_HI 7
`define CRC_PRESET_ZERO 16'h0000
`define CRC_PRESET_ONES 16'hFFFF
`define CRC_POLY 16'h8005
`define MASK_BITS 128

`endif

// file: verilog/wake_pkg.sv
// Types shared by the wake-up event control block.
// Assumes nothing beyond a SystemVerilog compiler.
package wake_pkg;

    // One received byte with frame markers
    typedef struct packed {
        logic valid;
        logic sof;
        logic eof;
        logic [7:0] data;
    } rx_byte_t;

    // One wake-up pattern as held in the store
    typedef struct packed {
        logic [127:0] mask;
        logic [15:0] crc;
        logic [7:0] offset;
    } pattern_t;

endpackage

// file: verilog/wake_crc_matcher.sv
// Per-pattern CRC-16 matcher over masked receive bytes.
// Assumes a byte stream on clk from the receive path, eof on a good frame.
`timescale 1ns/1ns
`include "wake_params.svh"

module wake_crc_matcher (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Pattern and options
    input wire wake_pkg::pattern_t pattern,
    input wire logic enable,
    input wire logic crc_preset_select,
    // Receive stream
    input wire wake_pkg::rx_byte_t rx_byte,
    // Result
    output logic hit
);
    logic [15:0] crc;
    logic [8:0] pos;
    logic [8:0] idx;
    logic [8:0] rel;
    logic sel;
    logic [15:0] crc_cur;
    logic [15:0] crc_nxt;

    // MSB-first CRC-16 over one byte
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int b = 7; b >= 0; b--) begin
            if (r[15] ^ d[b]) begin
                r = {r[14:0], 1'b0} ^ `CRC_POLY;
            end else begin
                r = {r[14:0], 1'b0};
            end
        end
        return r;
    endfunction

    // Byte position and mask selection
    always_comb begin
        idx = rx_byte.sof ? 9'h000 : pos;
        rel = idx - {1'b0, pattern.offset};
        sel = (idx >= {1'b0, pattern.offset}) && (rel < 9'h080) && pattern.mask[rel[6:0]];
        crc_cur = rx_byte.sof ? (crc_preset_select ? `CRC_PRESET_ONES
                                                   : `CRC_PRESET_ZERO) : crc;
        crc_nxt = sel ? crc_byte(crc_cur, rx_byte.data) : crc_cur;
    end

    // Accumulate; position saturates so long frames never wrap into the mask
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            crc <= `CRC_PRESET_ZERO;
            pos <= 9'h000;
        end else if (rx_byte.valid) begin
            crc <= crc_nxt;
            pos <= (idx == 9'h1FF) ? idx : idx + 9'h001;
        end
    end

    // Match pulse at end of frame
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            hit <= 1'b0;
        end else begin
            hit <= rx_byte.valid && rx_byte.eof && enable
                   && (crc_nxt == pattern.crc);
        end
    end

    // Assertions
    property p_crc_preset;
        @(posedge clk) disable iff (!reset_n)
        rx_byte.valid && rx_byte.sof && !sel |=>
            crc == ($past(crc_preset_select) ? 16'hFFFF : 16'h0000);
    endproperty
    a_crc_preset: assert property (p_crc_preset) else $error("crc preset wrong");

    property p_hit_cause;
        @(posedge clk) disable iff (!reset_n)
        hit |-> $past(enable) && $past(rx_byte.eof) && $past(crc_nxt) == $past(pattern.crc);
    endproperty
    a_hit_cause: assert property (p_hit_cause) else $error("hit without crc match");
endmodule

// file: verif/wake_link_model.sv
// Far-side model: link level, received frame bytes and wake-on-LAN pulses.
// Assumes the block samples all of these on the rising edge of clk.
`timescale 1ns/1ns

module wake_link_model (
    // Clock
    input wire logic clk,
    // Medium side
    output logic link_status,
    output wake_pkg::rx_byte_t rx_byte,
    output logic wol_packet_rx
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    logic frame_on = 1'b0;
    wake_pkg::rx_byte_t frame_byte = '0;
    logic [7:0] idle_cnt = 8'h00;

    initial begin
        link_status = 1'b0;
        wol_packet_rx = 1'b0;
    end

    // Idle data churns so a stale byte never looks held
    always @(posedge clk) begin
        idle_cnt <= idle_cnt + 8'h01;
    end

    assign rx_byte = frame_on ? frame_byte : {3'b000, idle_cnt};

    // Link level changes only just after an edge
    task automatic set_link(input logic up);
        @(posedge clk);
        link_status <= up;
    endtask

    // One-cycle packet indication
    task automatic pulse_wol();
        @(posedge clk);
        wol_packet_rx <= 1'b1;
        @(posedge clk);
        wol_packet_rx <= 1'b0;
    endtask

    // Eight-byte good frame, sof on first byte and eof on last
    task automatic send_frame(input logic [7:0] bytes [8]);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            frame_on <= 1'b1;
            frame_byte <= {1'b1, i == 0, i == 7, bytes[i]};
        end
        @(posedge clk);
        frame_on <= 1'b0;
    endtask
endmodule

// file: verif/tb_wake_event_control.sv
// Self-checking bench for the wake-up event control block.
// Assumes the link model drives the medium side; the bench is APB master.
`timescale 1ns/1ns
`include "wake_params.svh"

module tb_wake_event_control;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic soft_reset = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pm_enable_cfg = 1'b1;
    logic lan_wake_config = 1'b1;
    logic link_status;
    wake_pkg::rx_byte_t rx_byte;
    logic wol_packet_rx;
    logic pm_event_status_set;
    logic irq;
    int fail_count = 0;
    int checks = 0;
    int pm_count = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic err;
    logic [7:0] frame [8];
    logic [15:0] pat_crc;

    wake_event_control wake_event_control_i (.clk(clk), .reset_n(reset_n),
        .soft_reset(soft_reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pm_enable_cfg(pm_enable_cfg),
        .lan_wake_config(lan_wake_config), .link_status(link_status),
        .rx_byte(rx_byte), .wol_packet_rx(wol_packet_rx),
        .pm_event_status_set(pm_event_status_set), .irq(irq));

    wake_link_model wake_link_model_i (.clk(clk), .link_status(link_status),
        .rx_byte(rx_byte), .wol_packet_rx(wol_packet_rx));

    always #10 clk = ~clk;

    // Pulses are one cycle wide, so count them at every edge; also cut hangs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (pm_event_status_set === 1'b1) begin
            pm_count <= pm_count + 1;
        end
        if (cycles == 20000) begin
            fail_count = fail_count + 1;
            stop_test();
        end
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic stop_test();
        if (fail_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // One APB transfer; one idle edge first, then the request held until pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Reference CRC over frame bytes 2..5, MSB first
    function automatic logic [15:0] crc16(input logic [15:0] seed);
        logic [15:0] c;
        c = seed;
        for (int i = 2; i < 6; i++) begin
            for (int b = 7; b >= 0; b--) begin
                c = (c[15] ^ frame[i][b]) ? ((c << 1) ^ `CRC_POLY) : (c << 1);
            end
        end
        return c;
    endfunction

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        apb(1'b0, `WCS_ADDR, 32'h0);
        chk("ctl reset", rd, 32'h00000200);
        apb(1'b0, `IMASK_ADDR, 32'h0);
        chk("mask reset", rd, 32'h0);
        apb(1'b1, 8'h10, 32'hFFFFFFFF);
        chk("unmapped err", {31'h0, err}, 32'h1);
        chk("irq reset", {31'h0, irq}, 32'h0);
    endtask

    task automatic t_fields();
        apb(1'b1, `WCS_ADDR, 32'hFFFFFFF8);
        apb(1'b0, `WCS_ADDR, 32'h0);
        chk("ctl fields", rd, 32'h7E030700);
        apb(1'b1, `WCS_ADDR, 32'h0);
    endtask

    task automatic t_link();
        int p0;
        p0 = pm_count;
        apb(1'b1, `WCS_ADDR, 32'h00010100);
        wake_link_model_i.set_link(1'b1);
        wait_cyc(6);
        apb(1'b0, `WCS_ADDR, 32'h0);
        chk("link up flag", rd, 32'h00010101);
        chk("link pm", pm_count - p0, 32'h1);
        apb(1'b1, `WCS_ADDR, 32'h00010101);
        wake_link_model_i.set_link(1'b0);
        wait_cyc(6);
        apb(1'b0, `WCS_ADDR, 32'h0);
        chk("down ignored", rd, 32'h00010100);
        apb(1'b1, `WCS_ADDR, 32'h00020000);
        wake_link_model_i.set_link(1'b1);
        wait_cyc(6);
        apb(1'b0, `WCS_ADDR, 32'h0);
        chk("up ignored", rd, 32'h00020000);
        wake_link_model_i.set_link(1'b0);
        wait_cyc(6);
        apb(1'b0, `WCS_ADDR, 32'h0);
        chk("link down flag", rd, 32'h00020001);
        chk("no pm off", pm_count - p0, 32'h1);
        apb(1'b1, `WCS_ADDR, 32'h00000001);
    endtask

    task automatic t_wol_irq();
        int p0;
        p0 = pm_count;
        apb(1'b1, `WCS_ADDR, 32'h00000200);
        wake_link_model_i.pulse_wol();
        wait_cyc(4);
        apb(1'b0, `WCS_ADDR, 32'h0);
        chk("wol flag", rd, 32'h00000202);
        chk("wol pm", pm_count - p0, 32'h1);
        chk("irq masked", {31'h0, irq}, 32'h0);
        apb(1'b1, `IMASK_ADDR, 32'h00000002);
        wait_cyc(3);
        chk("irq on", {31'h0, irq}, 32'h1);
        soft_reset <= 1'b1;
        @(posedge clk);
        soft_reset <= 1'b0;
        wait_cyc(3);
        apb(1'b0, `WCS_ADDR, 32'h0);
        chk("flag kept", rd, 32'h00000202);
        apb(1'b1, `WCS_ADDR, 32'h00000202);
        apb(1'b0, `WCS_ADDR, 32'h0);
        chk("flag cleared", rd, 32'h00000200);
        pm_enable_cfg <= 1'b0;
        soft_reset <= 1'b1;
        @(posedge clk);
        soft_reset <= 1'b0;
        apb(1'b0, `WCS_ADDR, 32'h0);
        chk("wol default off", rd, 32'h0);
        pm_enable_cfg <= 1'b1;
    endtask

    // Frame with pattern two: mask bytes 0..3 from offset 2, CRC preset ones
    task automatic t_frame(input logic [31:0] ctl, input logic [31:0] exp, input int pm);
        int p0;
        p0 = pm_count;
        apb(1'b1, `WCS_ADDR, ctl);
        wake_link_model_i.send_frame(frame);
        wait_cyc(5);
        apb(1'b0, `WCS_ADDR, 32'h0);
        chk("frame flag", rd, exp);
        chk("frame pm", pm_count - p0, pm);
        apb(1'b1, `WCS_ADDR, 32'h00000004);
    endtask

    task automatic t_pattern();
        logic [31:0] w;
        logic [15:0] c0;
        for (int i = 0; i < 8; i++) frame[i] = 8'hA0 + i[7:0];
        pat_crc = crc16(`CRC_PRESET_ONES);
        c0 = crc16(`CRC_PRESET_ZERO);
        for (int i = 0; i < `PAT_WORDS; i++) begin
            w = (i == 0) ? 32'h12345678 : (i == 5) ? 32'h0000000F : 32'h0;
            if (i == 9) w = {pat_crc, 8'h00, 8'h02};
            apb(1'b1, `WPD_ADDR, w);
        end
        apb(1'b0, `WPD_ADDR, 32'h0);
        chk("store wrap", rd, 32'h12345678);
        t_frame(32'h50000400, 32'h50000404, 1);
        t_frame(32'h4E000400, 32'h4E000400, 0);
        t_frame(32'h10000400, 32'h10000400 | ((c0 == pat_crc) ? 4 : 0), 0);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_fields();
        t_link();
        t_wol_irq();
        t_pattern();
        wait_cyc(4);
        stop_test();
    end
endmodule
